// [csc_regs.svh]
// Register offsets, field positions, reset values and fixed addresses
// for the core system control block.
// Assumes a 32-bit register port with word-aligned byte offsets.
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// Register byte offsets
`define CSC_CTRL_OFS        4'h0
`define CSC_STATUS_OFS      4'h4
`define CSC_VBASE_OFS       4'h8
`define CSC_CYCLES_OFS      4'hc

// Control register fields
`define CSC_CTRL_FIQ_EN_BIT 0
`define CSC_CTRL_IRQ_EN_BIT 1
`define CSC_CTRL_RESET      2'h0

// Status register fields
`define CSC_ST_BIG_BIT      0
`define CSC_ST_HIVEC_BIT    1
`define CSC_ST_FIQ_BIT      2
`define CSC_ST_IRQ_BIT      3
`define CSC_ST_UNIDIR_BIT   4
`define CSC_ST_DEBUG_BIT    5
`define CSC_ST_STALL_BIT    6

// Exception vector bases
`define CSC_VBASE_LOW       32'h0000_0000
`define CSC_VBASE_HIGH      32'hffff_0000

`endif

// [csc_pkg.sv]
// Types shared by the core system control block and its bench.
// Assumes nothing beyond the constants header.
package csc_pkg;

    // Byte ordering seen by the core
    typedef enum logic [1:0] {
        CSC_ENDIAN_LITTLE = 2'b01,
        CSC_ENDIAN_BIG    = 2'b10
    } csc_endian_e;

    // Interrupt request pair, active high after qualification
    typedef struct packed {
        logic fiq;
        logic irq;
    } csc_irq_s;

    // Bus enable inputs and output enables
    typedef struct packed {
        logic instr_addr;
        logic data_addr;
        logic data;
        logic test;
    } csc_bus_en_s;

    // Register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } csc_reg_req_s;

endpackage : csc_pkg

// [csc_core_ctrl.sv]
// Core system control: configuration pins, interrupt qualification,
// effective clock forming, data bus direction and a small register port.
// Assumes every input but reset and the interrupt requests is synchronous to clk_i, which oversamples the
// main clock; the register master never waits and never overlaps strobes.

`include "csc_regs.svh"

module csc_core_ctrl #(
    parameter int DATA_W = 32,
    parameter int CNT_W  = 32
) (
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // Configuration and clocking pins
    input  wire logic                 endian_select_i,
    input  wire logic                 high_vector_select_i,
    input  wire logic                 main_clock_i,
    input  wire logic                 wait_stall_n_i,
    input  wire logic                 debug_clock_i,
    input  wire logic                 debug_state_i,
    output logic                      effective_clock_out_o,
    output logic                      core_phase2_o,
    output logic                      core_tick_o,
    // Interrupt pins
    input  wire logic                 fast_irq_n_i,
    input  wire logic                 normal_irq_n_i,
    input  wire logic                 irq_already_synchronous_i,
    output csc_pkg::csc_irq_s         take_irq_o,
    // Bus direction pins
    input  wire logic                 unidirectional_bus_select_i,
    input  wire csc_pkg::csc_bus_en_s bus_enable_i,
    output csc_pkg::csc_bus_en_s      bus_oe_o,
    input  wire logic                 core_write_i,
    input  wire logic [1:0]           core_byte_addr_i,
    input  wire logic [DATA_W-1:0]    core_wdata_i,
    input  wire logic [DATA_W-1:0]    read_data_in_i,
    output logic [DATA_W-1:0]         write_data_out_o,
    output logic                      write_data_out_oe_o,
    output logic [DATA_W-1:0]         core_rdata_o,
    output logic [7:0]                core_rbyte_o,
    // Vector and reset address
    output logic [31:0]               vector_base_o,
    output logic [31:0]               reset_fetch_addr_o,
    output csc_pkg::csc_endian_e      endian_o,
    // Register port
    input  wire csc_pkg::csc_reg_req_s reg_req_i,
    output logic [31:0]               reg_rdata_o
);
    import csc_pkg::*;

    // Byte lane within a word for a given address and byte order
    function automatic logic [1:0] lane_of(input logic [1:0] a, input logic big);
        lane_of = big ? ~a : a;
    endfunction : lane_of

    // Vector base for the high-vector select level
    function automatic logic [31:0] vbase_of(input logic hi);
        vbase_of = hi ? `CSC_VBASE_HIGH : `CSC_VBASE_LOW;
    endfunction : vbase_of

    // Rising edge of a sampled level from its current and previous values
    function automatic logic rose_of(input logic now, input logic was);
        rose_of = now & ~was;
    endfunction : rose_of

    logic [1:0]        ctrl_reg;
    logic              effective_clock_out_reg;
    logic              effective_clock_out_prev_reg;
    logic              tick_reg;
    logic [CNT_W-1:0]  cycles_reg;
    logic [1:0]        fiq_sync_reg;
    logic [1:0]        irq_sync_reg;
    csc_irq_s          take_reg;
    csc_irq_s          take_next;
    logic              fiq_level;
    logic              irq_level;
    logic              effective_clock_out_next;
    logic              big_reg;
    logic              hivec_reg;
    logic              boot_reg;
    logic [31:0]       boot_addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic              wdata_oe_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [7:0]        rbyte_reg;
    csc_bus_en_s       oe_reg;
    csc_bus_en_s       oe_next;
    logic [31:0]       rd_reg;
    logic [31:0]       rd_next;
    logic [31:0]       status_w;

    // Effective clock: outside debug wait low holds the clock high; debug passes the debug clock alone
    // clock OR wait
    always_comb begin
        if (debug_state_i) begin
            effective_clock_out_next = debug_clock_i;
        end else begin
            effective_clock_out_next = main_clock_i | ~wait_stall_n_i;
        end
    end

    // Registered copy of the effective clock and its previous level
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            effective_clock_out_reg      <= 1'b0;
            effective_clock_out_prev_reg <= 1'b0;
        end else begin
            effective_clock_out_reg      <= effective_clock_out_next;
            effective_clock_out_prev_reg <= effective_clock_out_reg;
        end
    end

    // Core step on each phase 1 to phase 2 edge; any stretch just delays it
    // phase tracking
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= rose_of(effective_clock_out_reg, effective_clock_out_prev_reg);
        end
    end

    // Count of effective clock rises; a stretched phase adds nothing
    // stretch tolerant
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cycles_reg <= '0;
        end else if (rose_of(effective_clock_out_reg, effective_clock_out_prev_reg)) begin
            cycles_reg <= cycles_reg + 1'b1;
        end
    end

    assign effective_clock_out_o = effective_clock_out_reg;
    assign core_phase2_o         = effective_clock_out_reg;
    assign core_tick_o           = tick_reg;

    // Two-stage synchronisers; only stage 2 is looked at, idle level high
    // two-stage synchroniser
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fiq_sync_reg <= 2'b11;
        end else begin
            fiq_sync_reg <= {fiq_sync_reg[0], fast_irq_n_i};
        end
    end

    // Normal request synchroniser, same depth as the fast one
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_sync_reg <= 2'b11;
        end else begin
            irq_sync_reg <= {irq_sync_reg[0], normal_irq_n_i};
        end
    end

    // Choose raw or synchronised request levels
    // sync bypass
    always_comb begin
        if (irq_already_synchronous_i) begin
            fiq_level = ~fast_irq_n_i;
            irq_level = ~normal_irq_n_i;
        end else begin
            fiq_level = ~fiq_sync_reg[1];
            irq_level = ~irq_sync_reg[1];
        end
    end

    // Gate by enables; fast request masks the normal one
    // fast interrupt take
    always_comb begin
        take_next.fiq = fiq_level & ctrl_reg[`CSC_CTRL_FIQ_EN_BIT];
        take_next.irq = irq_level & ctrl_reg[`CSC_CTRL_IRQ_EN_BIT] & ~take_next.fiq;
    end

    // Requests are levels; the source keeps them until answered
    // Take register, one cycle behind the qualified levels
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            take_reg <= '0;
        end else begin
            take_reg <= take_next;
        end
    end

    assign take_irq_o = take_reg;

    // Byte order pin tracked every cycle
    // byte order
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            big_reg <= 1'b0;
        end else begin
            big_reg <= endian_select_i;
        end
    end

    // Vector select pin tracked every cycle
    // vector base
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hivec_reg <= 1'b0;
        end else begin
            hivec_reg <= high_vector_select_i;
        end
    end

    assign endian_o      = big_reg ? CSC_ENDIAN_BIG : CSC_ENDIAN_LITTLE;
    assign vector_base_o = vbase_of(hivec_reg);

    // Reset is asynchronous; fetch address latched once after release
    // async reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_reg      <= 1'b1;
            boot_addr_reg <= `CSC_VBASE_LOW;
        end else if (boot_reg) begin
            boot_reg      <= 1'b0;
            boot_addr_reg <= vbase_of(high_vector_select_i);
        end
    end

    assign reset_fetch_addr_o = boot_addr_reg;

    // Output enables: all on in unidirectional mode, else per enable pin gated by the test enable, data also by core write
    // drive all
    always_comb begin
        if (unidirectional_bus_select_i) begin
            oe_next = '1;
        end else begin
            oe_next.instr_addr = bus_enable_i.instr_addr & bus_enable_i.test;
            oe_next.data_addr  = bus_enable_i.data_addr & bus_enable_i.test;
            oe_next.data       = bus_enable_i.data & bus_enable_i.test & core_write_i;
            oe_next.test       = bus_enable_i.test;
        end
    end

    // Registered output enables; all off while in reset
    // registered enables
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_reg <= '0;
        end else begin
            oe_reg <= oe_next;
        end
    end

    // Write data bus and its enable
    // separate buses
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdata_reg    <= '0;
            wdata_oe_reg <= 1'b0;
        end else begin
            wdata_reg    <= core_wdata_i;
            wdata_oe_reg <= oe_next.data;
        end
    end

    assign bus_oe_o            = oe_reg;
    assign write_data_out_o    = wdata_reg;
    assign write_data_out_oe_o = wdata_oe_reg;

    // Read data word and the byte chosen by byte order
    // lane select
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= '0;
            rbyte_reg <= 8'h00;
        end else begin
            rdata_reg <= read_data_in_i;
            rbyte_reg <= read_data_in_i[8*lane_of(core_byte_addr_i, endian_select_i) +: 8];
        end
    end

    assign core_rdata_o = rdata_reg;
    assign core_rbyte_o = rbyte_reg;

    // Control register: interrupt enables, both off after reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= `CSC_CTRL_RESET;
        end else if (reg_req_i.wr && reg_req_i.addr == `CSC_CTRL_OFS) begin
            ctrl_reg <= reg_req_i.wdata[1:0];
        end
    end

    // Status word from the block's own state and the raw bus mode, debug and wait pins
    always_comb begin
        status_w                     = 32'h0000_0000;
        status_w[`CSC_ST_BIG_BIT]    = big_reg;
        status_w[`CSC_ST_HIVEC_BIT]  = hivec_reg;
        status_w[`CSC_ST_FIQ_BIT]    = take_reg.fiq;
        status_w[`CSC_ST_IRQ_BIT]    = take_reg.irq;
        status_w[`CSC_ST_UNIDIR_BIT] = unidirectional_bus_select_i;
        status_w[`CSC_ST_DEBUG_BIT]  = debug_state_i;
        status_w[`CSC_ST_STALL_BIT]  = ~wait_stall_n_i;
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        case (reg_req_i.addr)
            `CSC_CTRL_OFS:   rd_next = {30'h0, ctrl_reg};
            `CSC_STATUS_OFS: rd_next = status_w;
            `CSC_VBASE_OFS:  rd_next = vbase_of(hivec_reg);
            `CSC_CYCLES_OFS: rd_next = 32'(cycles_reg);
            default:         rd_next = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_reg <= 32'h0000_0000;
        end else if (reg_req_i.rd) begin
            rd_reg <= rd_next;
        end else begin
            rd_reg <= 32'h0000_0000;
        end
    end

    assign reg_rdata_o = rd_reg;

endmodule : csc_core_ctrl

// [csc_core_ctrl_props.sv]
// Port checker for the core system control block.
// Assumes a bind into csc_core_ctrl, one clock domain on clk_i.
`include "csc_regs.svh"
module csc_core_ctrl_props (
    input wire logic                 clk_i,
    input wire logic                 rstn_i,
    input wire logic                 endian_select_i,
    input wire logic                 high_vector_select_i,
    input wire logic                 main_clock_i,
    input wire logic                 wait_stall_n_i,
    input wire logic                 debug_clock_i,
    input wire logic                 debug_state_i,
    input wire logic                 effective_clock_out_o,
    input wire logic                 core_tick_o,
    input wire logic                 fast_irq_n_i,
    input wire logic                 irq_already_synchronous_i,
    input wire csc_pkg::csc_irq_s    take_irq_o,
    input wire logic                 unidirectional_bus_select_i,
    input wire csc_pkg::csc_bus_en_s bus_oe_o,
    input wire logic                 write_data_out_oe_o,
    input wire logic [31:0]          vector_base_o,
    input wire csc_pkg::csc_endian_e endian_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import csc_pkg::*;
    logic live_reg;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // High once the previous edge was out of reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            live_reg <= 1'b0;
        else
            live_reg <= 1'b1;
    end

    effective_clock_out_form_a: assert property (live_reg && !$past(debug_state_i) |->
        effective_clock_out_o == ($past(main_clock_i) | !$past(wait_stall_n_i)))
        else $error("effective clock wrong");
    effective_clock_out_debug_a: assert property (live_reg && $past(debug_state_i) |->
        effective_clock_out_o == $past(debug_clock_i))
        else $error("debug clock not passed out");
    tick_rise_a: assert property (live_reg |-> core_tick_o ==
        ($past(effective_clock_out_o) && !$past(effective_clock_out_o, 2)))
        else $error("core tick misplaced");
    fiq_cause_a: assert property (live_reg && $past(irq_already_synchronous_i) &&
        take_irq_o.fiq |-> !$past(fast_irq_n_i))
        else $error("fast interrupt taken without request");
    fiq_first_a: assert property (take_irq_o.fiq |-> !take_irq_o.irq)
        else $error("normal interrupt beside fast");
    sync_delay_a: assert property (live_reg && !$past(irq_already_synchronous_i) &&
        $past(fast_irq_n_i, 3) |-> !take_irq_o.fiq)
        else $error("synchronised interrupt too early");
    uni_drive_a: assert property (live_reg && $past(unidirectional_bus_select_i) |->
        bus_oe_o == 4'hf && write_data_out_oe_o)
        else $error("unidirectional outputs not driven");
    vec_base_a: assert property (live_reg |-> vector_base_o ==
        ($past(high_vector_select_i) ? `CSC_VBASE_HIGH : `CSC_VBASE_LOW))
        else $error("vector base wrong");
    endian_map_a: assert property (live_reg |-> endian_o ==
        ($past(endian_select_i) ? CSC_ENDIAN_BIG : CSC_ENDIAN_LITTLE))
        else $error("byte order wrong");
    reset_hold_a: assert property (disable iff (1'b0) !rstn_i |->
        take_irq_o == 2'h0 && endian_o == CSC_ENDIAN_LITTLE && bus_oe_o == 4'h0)
        else $error("outputs not held in reset");
endmodule : csc_core_ctrl_props

// [csc_sys_model.sv]
// System-side model: main clock, wait stall, debug clock, interrupt lines.
// Assumes the bench raises its stall and interrupt requests by level.
module csc_sys_model (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              stall_i,
    input  wire logic              fiq_i,
    input  wire logic              irq_i,
    input  wire csc_pkg::csc_irq_s take_i,
    output logic                   main_clock_o,
    output logic                   wait_stall_n_o,
    output logic                   debug_clock_o,
    output logic                   fast_irq_n_o,
    output logic                   normal_irq_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import csc_pkg::*;
    logic [1:0] div_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end
    assign main_clock_o  = div_reg[1];
    assign debug_clock_o = div_reg[0];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            wait_stall_n_o <= 1'b1;
        else if (div_reg == 2'h2)
            wait_stall_n_o <= !stall_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fast_irq_n_o   <= 1'b1;
            normal_irq_n_o <= 1'b1;
        end else begin
            fast_irq_n_o   <= !(fiq_i || (!fast_irq_n_o && !take_i.fiq));
            normal_irq_n_o <= !(irq_i || (!normal_irq_n_o && !take_i.irq));
        end
    end
endmodule : csc_sys_model

// [csc_core_ctrl_tb.sv]
// Bench for the core system control block: registers, pins, interrupts.
// Assumes csc_sys_model on the system side and the checker bound below.
module csc_core_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import csc_pkg::*;
    logic         clk_i = 1'b0;
    logic         rstn_i;
    logic         esel = 1'b0, hv = 1'b0, dbg = 1'b0, byp = 1'b1, uni = 1'b0, cw = 1'b0;
    logic         stall = 1'b0, fiq = 1'b0, irq = 1'b0;
    logic         mclk, wait_n, dclk, fiq_n, irq_n, effective_clock_out, d_oe, ph2;
    logic [1:0]   baddr = 2'h1;
    logic [31:0]  wd = 32'ha5a55a5a, rd_in = 32'h44332211;
    logic [31:0]  rdata, wdo, rdo, vbase, start, got;
    logic [7:0]   rbyte;
    csc_irq_s     take;
    csc_bus_en_s  ben = 4'hf, boe;
    csc_endian_e  endian;
    csc_reg_req_s req = '0;
    int           miscompares = 0, num_checks = 0;

    // Clock at 200 MHz
    always #2.5 clk_i = ~clk_i;

    csc_sys_model csc_sys_model_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .stall_i(stall), .fiq_i(fiq), .irq_i(irq),
        .take_i(take), .main_clock_o(mclk), .wait_stall_n_o(wait_n),
        .debug_clock_o(dclk), .fast_irq_n_o(fiq_n), .normal_irq_n_o(irq_n)
    );

    csc_core_ctrl csc_core_ctrl_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .endian_select_i(esel), .high_vector_select_i(hv),
        .main_clock_i(mclk), .wait_stall_n_i(wait_n), .debug_clock_i(dclk),
        .debug_state_i(dbg), .effective_clock_out_o(effective_clock_out), .core_phase2_o(ph2), .core_tick_o(),
        .fast_irq_n_i(fiq_n), .normal_irq_n_i(irq_n), .irq_already_synchronous_i(byp),
        .take_irq_o(take), .unidirectional_bus_select_i(uni), .bus_enable_i(ben),
        .bus_oe_o(boe), .core_write_i(cw), .core_byte_addr_i(baddr), .core_wdata_i(wd),
        .read_data_in_i(rd_in), .write_data_out_o(wdo), .write_data_out_oe_o(d_oe),
        .core_rdata_o(rdo), .core_rbyte_o(rbyte), .vector_base_o(vbase),
        .reset_fetch_addr_o(start), .endian_o(endian), .reg_req_i(req), .reg_rdata_o(rdata)
    );

    // Counts a comparison, reports a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Waits n edges and lets their updates land
    task automatic look(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : look

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        req <= '0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe; kept in got
    task automatic reg_get(input logic [3:0] a);
        @(posedge clk_i);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_i);
        req <= '0;
        #1 got = rdata;
    endtask : reg_get

    // Reads one word and compares it
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
        reg_get(a);
        check(got, exp);
    endtask : reg_rd

    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    // Cuts a hung run short
    initial begin
        #100us;
        miscompares++;
        end_of_test();
    end

    initial begin
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        reg_rd(4'h0, 32'h0);
        reg_wr(4'h2, 32'hffffffff);
        reg_rd(4'h2, 32'h0);
        reg_rd(4'h8, 32'h0);
        check(start, 32'h0);
        @(posedge clk_i);
        esel <= 1'b1;
        hv <= 1'b1;
        look(3);
        check(vbase, 32'hffff0000);
        check(endian, CSC_ENDIAN_BIG);
        check(rbyte, 8'h33);
        reg_rd(4'h4, 32'h3);
        @(posedge clk_i);
        esel <= 1'b0;
        uni <= 1'b1;
        ben <= 4'h0;
        look(3);
        check(rbyte, 8'h22);
        check(boe, 4'hf);
        check(wdo, 32'ha5a55a5a);
        check(rdo, 32'h44332211);
        @(posedge clk_i);
        uni <= 1'b0;
        ben <= 4'hf;
        look(2);
        check(boe, 4'hd);
        @(posedge clk_i);
        cw <= 1'b1;
        ben <= 4'he;
        look(2);
        check(boe, 4'h0);
        @(posedge clk_i);
        ben <= 4'hf;
        look(2);
        check(d_oe, 1'b1);
        // Both requests, then the fast one withdrawn, then the normal one gated
        reg_wr(4'h0, 32'h3);
        fiq <= 1'b1;
        irq <= 1'b1;
        look(2);
        check(take, 2'h2);
        @(posedge clk_i);
        fiq <= 1'b0;
        look(2);
        check(take, 2'h1);
        @(posedge clk_i);
        irq <= 1'b0;
        reg_wr(4'h0, 32'h1);
        irq <= 1'b1;
        look(3);
        check(take, 2'h0);
        // Synchronised request lands three cycles late
        @(posedge clk_i);
        byp <= 1'b0;
        fiq <= 1'b1;
        look(3);
        check(take, 2'h0);
        look(1);
        check(take, 2'h2);
        @(posedge clk_i);
        stall <= 1'b1;
        look(8);
        check(effective_clock_out, 1'b1);
        check(ph2, 1'b1);
        reg_rd(4'h4, 32'h46);
        // A stretched phase 2 adds no core cycles
        reg_get(4'hc);
        look(8);
        reg_rd(4'hc, got);
        @(posedge clk_i);
        stall <= 1'b0;
        dbg <= 1'b1;
        esel <= 1'b1;
        look(6);
        check(effective_clock_out ^ dclk, 1'b1);
        // Debug clock rises once in every two edges
        reg_get(4'hc);
        reg_rd(4'hc, got + 32'h1);
        // Reset in mid-run acts before the next edge
        @(posedge clk_i);
        rstn_i <= 1'b0;
        #1 check(take, 2'h0);
        check(endian, CSC_ENDIAN_LITTLE);
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        dbg <= 1'b0;
        reg_rd(4'h0, 32'h0);
        check(start, 32'hffff0000);
        end_of_test();
    end
endmodule : csc_core_ctrl_tb

bind csc_core_ctrl csc_core_ctrl_props csc_core_ctrl_props_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .endian_select_i(endian_select_i),
    .high_vector_select_i(high_vector_select_i), .main_clock_i(main_clock_i),
    .wait_stall_n_i(wait_stall_n_i), .debug_clock_i(debug_clock_i),
    .debug_state_i(debug_state_i), .effective_clock_out_o(effective_clock_out_o),
    .core_tick_o(core_tick_o),
    .fast_irq_n_i(fast_irq_n_i), .irq_already_synchronous_i(irq_already_synchronous_i),
    .take_irq_o(take_irq_o), .unidirectional_bus_select_i(unidirectional_bus_select_i),
    .bus_oe_o(bus_oe_o), .write_data_out_oe_o(write_data_out_oe_o),
    .vector_base_o(vector_base_o), .endian_o(endian_o)
);
